/* File: soak_program_sequencer_tb_top.sv */
// self-checking bench for the soak program sequencer
`timescale 1ns/1ps
`default_nettype none
module soak_program_sequencer_tb_top;
    logic               clk = 1'b0;
    logic               rst_b = 1'b0;
    logic               psel = 1'b0;
    logic               penable = 1'b0;
    logic               pwrite = 1'b0;
    logic [7:0]         paddr = 8'h00;
    logic [31:0]        pwdata = 32'h0;
    logic [31:0]        prdata, rd_q;
    logic               pready, pslverr, run_mode, prog_end, aux1_out, alarm1_out, err_q;
    logic               disp_show_end, comm_end_status, nvm_write, evs, evc, ph;
    logic               st_cmd = 1'b0;
    logic               cl_cmd = 1'b0;
    logic               hfit = 1'b0;
    logic               a1s = 1'b1;
    logic signed [15:0] pv = 16'h0064;
    logic signed [15:0] sp = 16'h0064;
    int                 num_errors = 0;
    int                 total_checks = 0;
    sps_sequencer #(.SEC_CYCLES(10), .BLINK_CYCLES(5)) dut (.clk, .rst_b, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata, .pv, .sp,
        .evt_start_pin(evs), .evt_clear_pin(evc), .cooling_out_used(1'b0),
        .heater_alarm_fitted(hfit), .alarm1_src(a1s), .heater_alarm_src(1'b0),
        .cooling_src(1'b0), .run_mode, .prog_end, .aux1_out, .alarm1_out, .disp_show_end,
        .comm_end_status, .nvm_write);
    sps_partner u_evt (.clk, .start_cmd(st_cmd), .clear_cmd(cl_cmd), .evt_start_pin(evs),
        .evt_clear_pin(evc));
    initial forever #10 clk = ~clk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    task automatic chb(input logic seen, input logic exp);
        chk({31'h0, seen}, {31'h0, exp});
    endtask : chb
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    // one apb transfer; the request holds until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd_q = prdata;
        err_q = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic wait_end(input int n);
        for (int i = 0; i < n && prog_end !== 1'b1; i++) @(posedge clk);
    endtask : wait_end
    task automatic t_regs;
        apb(1'b1, sps_pkg::OFS_WAIT_BAND, 32'h0000_2710);
        apb(1'b0, sps_pkg::OFS_WAIT_BAND, 32'h0);
        chk(rd_q, 32'h0);
        apb(1'b1, sps_pkg::OFS_WAIT_BAND, 32'h0001_270f);
        apb(1'b0, sps_pkg::OFS_WAIT_BAND, 32'h0);
        chk(rd_q, 32'h0001_270f);
        apb(1'b0, 8'h40, 32'h0);
        chb(err_q, 1'b1);
    endtask : t_regs
    task automatic t_off;
        apb(1'b1, sps_pkg::OFS_START, 32'h1);
        tick(20);
        chb(run_mode, 1'b0);
        apb(1'b0, sps_pkg::OFS_STATUS, 32'h0);
        chk(rd_q & 32'h2, 32'h0);
    endtask : t_off
    // band off and pv far away: 2 s of 10 cycles must still expire
    task automatic t_stop;
        apb(1'b1, sps_pkg::OFS_WAIT_BAND, 32'h0);
        apb(1'b1, sps_pkg::OFS_SOAK_UNIT, 32'h0);
        apb(1'b1, sps_pkg::OFS_SOAK_DUR, 32'h2);
        apb(1'b1, sps_pkg::OFS_PATTERN, 32'h1);
        pv <= 16'h00c8;
        apb(1'b1, sps_pkg::OFS_START, 32'h1);
        tick(2);
        chb(run_mode, 1'b1);
        tick(14);
        chb(prog_end, 1'b0);
        wait_end(12);
        chb(prog_end, 1'b1);
        chb(aux1_out, 1'b1);
        chb(run_mode, 1'b0);
        tick(1);
        chb(comm_end_status, 1'b1);
        apb(1'b1, sps_pkg::OFS_START, 32'h0);
        tick(2);
        chb(aux1_out, 1'b0);
        apb(1'b1, sps_pkg::OFS_COMM_CMD, 32'h1);
        tick(5);
        apb(1'b1, sps_pkg::OFS_COMM_CMD, 32'h2);
        tick(3);
        chb(run_mode, 1'b0);
        apb(1'b0, sps_pkg::OFS_NVM_CNT, 32'h0);
        chk(rd_q, 32'h4);
    endtask : t_stop
    task automatic t_keep_running_pattern;
        apb(1'b1, sps_pkg::OFS_PATTERN, 32'h2);
        apb(1'b1, sps_pkg::OFS_WAIT_BAND, 32'h5);
        apb(1'b1, sps_pkg::OFS_EVT_ASGN, 32'h2);
        apb(1'b1, sps_pkg::OFS_START, 32'h1);
        tick(40);
        chb(prog_end, 1'b0);
        pv <= sp + 16'h0005;
        apb(1'b1, sps_pkg::OFS_RUNSTOP, 32'h0);
        apb(1'b1, sps_pkg::OFS_RUNSTOP, 32'h1);
        wait_end(30);
        chb(prog_end, 1'b1);
        chb(run_mode, 1'b1);
        ph = disp_show_end;
        tick(5);
        chb(disp_show_end, ~ph);
        cl_cmd <= 1'b1;
        tick(8);
        chb(prog_end, 1'b0);
        cl_cmd <= 1'b0;
    endtask : t_keep_running_pattern
    task automatic t_evt;
        apb(1'b1, sps_pkg::OFS_START, 32'h0);
        apb(1'b1, sps_pkg::OFS_EVT_ASGN, 32'h1);
        st_cmd <= 1'b1;
        tick(8);
        chb(run_mode, 1'b1);
        apb(1'b1, sps_pkg::OFS_START, 32'h0);
        apb(1'b1, sps_pkg::OFS_COMM_CMD, 32'h2);
        apb(1'b0, sps_pkg::OFS_START, 32'h0);
        chk(rd_q & 32'h1, 32'h1);
        st_cmd <= 1'b0;
        tick(8);
        hfit <= 1'b1;
        apb(1'b1, sps_pkg::OFS_PATTERN, 32'h0);
        apb(1'b0, sps_pkg::OFS_EVT_ASGN, 32'h0);
        chk(rd_q & 32'h1, 32'h0);
        apb(1'b0, sps_pkg::OFS_OUT_ASGN, 32'h0);
        chk(rd_q & 32'h700, 32'h300);
        chb(alarm1_out, 1'b0);
    endtask : t_evt
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : tally_and_finish
    // few start/reset cycles in all, sparing the nvm endurance
    initial begin
        tick(20);
        rst_b <= 1'b1;
        tick(1);
        t_regs;
        t_off;
        t_stop;
        t_keep_running_pattern;
        t_evt;
        tally_and_finish;
    end
    // the whole run needs well under a thousand cycles
    initial begin
        tick(5000);
        num_errors++;
        tally_and_finish;
    end
endmodule : soak_program_sequencer_tb_top
`default_nettype wire

/* File: sps_asserts.sv */
// port checker for the soak program sequencer
`timescale 1ns/1ps
`default_nettype none
module sps_asserts #(
    parameter int BLINK_CYCLES = 5
) (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_b,
    // apb side
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    // program outputs
    input wire logic        run_mode,
    input wire logic        prog_end,
    input wire logic        disp_show_end,
    input wire logic        comm_end_status,
    input wire logic        nvm_write
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic [31:0] hold_r;
    logic        disp_q_r;
    // cycles since the display phase last moved, so a stuck blink shows up
    always_ff @(posedge clk) begin
        disp_q_r <= disp_show_end;
        hold_r   <= (!prog_end || disp_q_r != disp_show_end) ? 32'h0 : hold_r + 32'h1;
    end
    property p_ready; pready; endproperty
    a_ready: assert property (p_ready) else $error("pready low");
    property p_err; pslverr |-> psel && penable; endproperty
    a_err: assert property (p_err) else $error("pslverr outside access");
    property p_rdhold; $past(psel && penable) && !psel |-> $stable(prdata); endproperty
    a_rdhold: assert property (p_rdhold) else $error("prdata moved after access");
    property p_rst; $rose(rst_b) |-> !run_mode && !prog_end && !nvm_write; endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
    property p_nvm; nvm_write |=> !nvm_write; endproperty
    a_nvm: assert property (p_nvm) else $error("nvm pulse too long");
    property p_comm; $changed(prog_end) |-> ##[0:1] (comm_end_status == prog_end); endproperty
    a_comm: assert property (p_comm) else $error("comm status lags end");
    property p_disp; !prog_end && !$past(prog_end) |-> !disp_show_end; endproperty
    a_disp: assert property (p_disp) else $error("end shown while not ended");
    property p_blink; hold_r <= BLINK_CYCLES; endproperty
    a_blink: assert property (p_blink) else $error("end display not alternating");
    c_end: cover property (prog_end);
    c_nvm: cover property (nvm_write);
    c_err: cover property (pslverr);
endmodule : sps_asserts
bind sps_sequencer sps_asserts #(.BLINK_CYCLES(BLINK_CYCLES)) u_chk (.clk, .rst_b, .psel,
    .penable, .pready, .pslverr, .prdata, .run_mode, .prog_end, .disp_show_end,
    .comm_end_status, .nvm_write);
`default_nettype wire

/* File: sps_partner.sv */
// event input model: start and clear contacts seen by the sequencer
`timescale 1ns/1ps
`default_nettype none
module sps_partner (
    // clock and bench commands
    input  wire logic clk,
    input  wire logic start_cmd,
    input  wire logic clear_cmd,
    // event pins
    output logic      evt_start_pin,
    output logic      evt_clear_pin
);
    // contacts move once per clock at most, like a debounced switch
    always_ff @(posedge clk) begin
        evt_start_pin <= start_cmd;
        evt_clear_pin <= clear_cmd;
    end
endmodule : sps_partner
`default_nettype wire

/* File: sps_pkg.sv */
// package of constants and types for the soak program sequencer
// Functional notes
// - start setting reset-to-start begins a run
// - soak time reached raises end flag and output
// - stop pattern halts control at end
// - continue pattern keeps run mode at end
// - pattern off disables all program operation
// - timer counts only inside set point band
// - band off means count continuously
// - temperature band off or 0.1 to 999.9
// - analog band off or 0.01 to 99.99
// - start from setting, event or command
// - event-assigned start is read-only monitor
// - pattern off clears event start assignment
// - end state alternates display every 0.5 s
// - pattern enable assigns end to aux 1; cooling instead when cooling_out_used
// - pattern off restores alarm 1 default
// - start-to-reset clears end flag and output
// - event input can clear end status
// - start forces run, early reset forces stop
// - start while running leaves mode unchanged
// - manual stop keeps soak timer going
// - end condition visible in comms status
// - start and reset each write non-volatile memory
package sps_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_PATTERN   = 8'h00;
    localparam logic [7:0] OFS_START     = 8'h04;
    localparam logic [7:0] OFS_SOAK_DUR  = 8'h08;
    localparam logic [7:0] OFS_SOAK_UNIT = 8'h0c;
    localparam logic [7:0] OFS_WAIT_BAND = 8'h10;
    localparam logic [7:0] OFS_EVT_ASGN  = 8'h14;
    localparam logic [7:0] OFS_COMM_CMD  = 8'h18;
    localparam logic [7:0] OFS_RUNSTOP   = 8'h1c;
    localparam logic [7:0] OFS_STATUS    = 8'h20;
    localparam logic [7:0] OFS_ELAPSED   = 8'h24;
    localparam logic [7:0] OFS_REMAIN    = 8'h28;
    localparam logic [7:0] OFS_OUT_ASGN  = 8'h2c;
    localparam logic [7:0] OFS_NVM_CNT   = 8'h30;
    // field positions
    localparam int BIT_EVT_START = 0;
    localparam int BIT_EVT_CLEAR = 1;
    localparam int BIT_CMD_START = 0;
    localparam int BIT_CMD_RESET = 1;
    localparam int BIT_BAND_ANA  = 16;
    localparam int POS_FIRST_ALARM_FUNCTION_FN   = 8;
    // ranges and reset values
    localparam logic [13:0] SOAK_MIN  = 14'h0001;
    localparam logic [13:0] SOAK_MAX  = 14'h270f;  // 9999
    localparam logic [13:0] SOAK_RST  = 14'h0001;
    localparam logic [15:0] BAND_OFF  = 16'h0000;
    localparam logic [15:0] BAND_MIN  = 16'h0001;  // 0.1 or 0.01
    localparam logic [15:0] BAND_MAX  = 16'h270f;  // 999.9 or 99.99
    // timing
    localparam int CLK_HZ        = 50000000;
    localparam int SEC_PER_MIN   = 60;
    localparam int SEC_PER_HOUR  = 3600;
    localparam int BLINK_MS      = 500;
    localparam int SEC_CYCLES    = CLK_HZ;
    localparam int BLINK_CYCLES  = CLK_HZ / 1000 * BLINK_MS;
    typedef enum logic [1:0] {PAT_OFF, PAT_STOP, PAT_KEEP_RUNNING_PATTERN} sps_pattern_t;
    typedef enum logic [1:0] {UNIT_SEC, UNIT_MIN, UNIT_HOUR} sps_unit_t;
    typedef enum logic [2:0] {FN_NONE, FN_END, FN_ALARM, FN_HEATER, FN_COOL} sps_outfn_t;
endpackage : sps_pkg

/* File: sps_sequencer.sv */
// soak program sequencer: apb registers, start/reset control, soak timer and end handling
`timescale 1ns/1ps
`default_nettype none
module sps_sequencer #(
    parameter int SEC_CYCLES   = sps_pkg::SEC_CYCLES,
    parameter int BLINK_CYCLES = sps_pkg::BLINK_CYCLES
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata,
    // process values, same units as the wait band
    input  wire logic signed [15:0] pv,
    input  wire logic signed [15:0] sp,
    // event input pins, asynchronous
    input  wire logic        evt_start_pin,
    input  wire logic        evt_clear_pin,
    // configuration and output source signals from the rest of the controller
    input  wire logic        cooling_out_used,
    input  wire logic        heater_alarm_fitted,
    input  wire logic        alarm1_src,
    input  wire logic        heater_alarm_src,
    input  wire logic        cooling_src,
    // outputs
    output logic             run_mode,
    output logic             prog_end,
    output logic             aux1_out,
    output logic             alarm1_out,
    output logic             disp_show_end,
    output logic             comm_end_status,
    output logic             nvm_write
);
    localparam int SECW = $clog2(SEC_CYCLES + 1);
    localparam int BLKW = $clog2(BLINK_CYCLES + 1);
    localparam logic [SECW-1:0] SEC_LAST = SECW'(SEC_CYCLES - 1);
    localparam logic [BLKW-1:0] BLK_LAST = BLKW'(BLINK_CYCLES - 1);
    localparam logic [11:0] MIN_LAST  = 12'(sps_pkg::SEC_PER_MIN - 1);
    localparam logic [11:0] HOUR_LAST = 12'(sps_pkg::SEC_PER_HOUR - 1);

    // configuration registers
    sps_pkg::sps_pattern_t pattern_r;
    sps_pkg::sps_unit_t    unit_r;
    sps_pkg::sps_outfn_t   aux1_fn_r;
    sps_pkg::sps_outfn_t   alarm1_fn_r;
    logic        start_set_r;
    logic [13:0] soak_dur_r;
    logic [15:0] band_r;
    logic        band_ana_r;
    logic        evt_start_en_r;
    logic        evt_clear_en_r;
    // program state
    logic        run_r;
    logic        active_r;
    logic        end_r;
    logic        start_lvl_prev_r;
    logic [13:0] elapsed_r;
    logic [SECW-1:0] sec_cnt_r;
    logic [11:0] sub_cnt_r;
    logic [BLKW-1:0] blink_cnt_r;
    logic        blink_r;
    logic        nvm_r;
    logic [15:0] nvm_cnt_r;
    logic [31:0] prdata_r;
    logic        pslverr_r;

    // event input synchronisers: three flops, accepted once the last two agree
    logic [1:0] ev_pin;
    logic [1:0] ev_s1_r;
    logic [1:0] ev_s2_r;
    logic [1:0] ev_s3_r;
    logic [1:0] ev_r;
    logic       ev_clear_prev_r;
    assign ev_pin = {evt_clear_pin, evt_start_pin};
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_sync
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    ev_s1_r[gi] <= 1'b0;
                    ev_s2_r[gi] <= 1'b0;
                    ev_s3_r[gi] <= 1'b0;
                    ev_r[gi]    <= 1'b0;
                end else begin
                    ev_s1_r[gi] <= ev_pin[gi];
                    ev_s2_r[gi] <= ev_s1_r[gi];
                    ev_s3_r[gi] <= ev_s2_r[gi];
                    if (ev_s2_r[gi] == ev_s3_r[gi]) begin
                        ev_r[gi] <= ev_s3_r[gi];
                    end
                end
            end
        end
    endgenerate

    // apb decode; the slave answers with no wait states
    logic wr_acc;
    logic rd_setup;
    logic addr_ok;
    assign wr_acc   = psel && penable && pwrite;
    assign rd_setup = psel && !penable;
    always_comb begin
        unique case (paddr)
            sps_pkg::OFS_PATTERN, sps_pkg::OFS_START, sps_pkg::OFS_SOAK_DUR,
            sps_pkg::OFS_SOAK_UNIT, sps_pkg::OFS_WAIT_BAND, sps_pkg::OFS_EVT_ASGN,
            sps_pkg::OFS_COMM_CMD, sps_pkg::OFS_RUNSTOP, sps_pkg::OFS_STATUS,
            sps_pkg::OFS_ELAPSED, sps_pkg::OFS_REMAIN, sps_pkg::OFS_OUT_ASGN,
            sps_pkg::OFS_NVM_CNT: addr_ok = 1'b1;
            default:              addr_ok = 1'b0;
        endcase
    end
    logic wr_pattern;
    logic wr_start;
    logic wr_cmd;
    logic wr_runstop;
    logic [1:0] wpat;
    assign wr_pattern = wr_acc && paddr == sps_pkg::OFS_PATTERN
                        && pwdata[1:0] <= 2'(sps_pkg::PAT_KEEP_RUNNING_PATTERN);
    assign wr_start   = wr_acc && paddr == sps_pkg::OFS_START;
    assign wr_cmd     = wr_acc && paddr == sps_pkg::OFS_COMM_CMD;
    assign wr_runstop = wr_acc && paddr == sps_pkg::OFS_RUNSTOP;
    assign wpat       = pwdata[1:0];

    // program start level: the event pin when assigned, otherwise the setting
    logic pat_on;
    logic start_lvl;
    logic go_evt;
    logic rst_evt;
    logic expire;
    assign pat_on    = pattern_r != sps_pkg::PAT_OFF;
    assign start_lvl = evt_start_en_r ? ev_r[0] : start_set_r;
    assign go_evt    = pat_on && start_lvl && !start_lvl_prev_r;
    assign rst_evt   = pat_on && !start_lvl && start_lvl_prev_r;

    // wait band check; zero band means off and counts as always inside
    logic signed [16:0] diff;
    logic [16:0]        adiff;
    logic               in_band;
    assign diff    = 17'(pv) - 17'(sp);
    assign adiff   = diff[16] ? 17'(-diff) : 17'(diff);
    assign in_band = (band_r == sps_pkg::BAND_OFF) || (adiff <= {1'b0, band_r});

    // timer base: second prescaler, then seconds per unit; pauses out of band
    logic tick_en;
    logic sec_done;
    logic unit_done;
    logic [11:0] sub_last;
    assign tick_en  = active_r && in_band;
    assign sec_done = tick_en && sec_cnt_r == SEC_LAST;
    always_comb begin
        unique case (unit_r)
            sps_pkg::UNIT_MIN:  sub_last = MIN_LAST;
            sps_pkg::UNIT_HOUR: sub_last = HOUR_LAST;
            default:            sub_last = 12'h000;
        endcase
    end
    assign unit_done = sec_done && sub_cnt_r == sub_last;
    assign expire    = unit_done && (elapsed_r + 14'h0001 >= soak_dur_r);

    // prescalers restart on each start so every run begins clean
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sec_cnt_r <= '0;
            sub_cnt_r <= 12'h000;
        end else if (go_evt) begin
            sec_cnt_r <= '0;
            sub_cnt_r <= 12'h000;
        end else if (tick_en) begin
            sec_cnt_r <= sec_done ? '0 : sec_cnt_r + SECW'(1);
            if (sec_done) begin
                sub_cnt_r <= unit_done ? 12'h000 : sub_cnt_r + 12'h001;
            end
        end
    end

    // elapsed soak units; cleared on start, held on reset for monitoring
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            elapsed_r <= 14'h0000;
        end else if (go_evt) begin
            elapsed_r <= 14'h0000;
        end else if (unit_done) begin
            elapsed_r <= elapsed_r + 14'h0001;
        end
    end

    // program activity, end flag and start-level history
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            active_r         <= 1'b0;
            end_r            <= 1'b0;
            start_lvl_prev_r <= 1'b0;
            ev_clear_prev_r  <= 1'b0;
        end else begin
            start_lvl_prev_r <= pat_on && start_lvl;
            ev_clear_prev_r  <= ev_r[1];
            if (!pat_on) begin
                active_r <= 1'b0;
            end else if (go_evt) begin
                active_r <= 1'b1;
            end else if (rst_evt || expire) begin
                active_r <= 1'b0;
            end
            // a new expiry wins over a clear arriving in the same cycle
            if (expire) begin
                end_r <= 1'b1;
            end else if (go_evt || rst_evt) begin
                end_r <= 1'b0;
            end else if (evt_clear_en_r && ev_r[1] && !ev_clear_prev_r) begin
                end_r <= 1'b0;
            end else if (!pat_on) begin
                end_r <= 1'b0;
            end
        end
    end

    // run/stop mode: program events override a key write in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            run_r <= 1'b0;
        end else if (go_evt) begin
            run_r <= 1'b1;
        end else if (rst_evt && active_r) begin
            run_r <= 1'b0;
        end else if (expire && pattern_r == sps_pkg::PAT_STOP) begin
            run_r <= 1'b0;
        end else if (expire) begin
            run_r <= run_r;
        end else if (wr_runstop) begin
            run_r <= pwdata[0];
        end
    end

    // start setting: key write or comm command, both refused while the event owns it
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            start_set_r <= 1'b0;
        end else if (!pat_on) begin
            start_set_r <= 1'b0;
        end else if (evt_start_en_r) begin
            start_set_r <= ev_r[0];
        end else if (wr_start) begin
            start_set_r <= pwdata[0];
        end else if (wr_cmd && pwdata[sps_pkg::BIT_CMD_START]) begin
            start_set_r <= 1'b1;
        end else if (wr_cmd && pwdata[sps_pkg::BIT_CMD_RESET]) begin
            start_set_r <= 1'b0;
        end
    end

    // pattern, event assignments and output function assignments
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pattern_r      <= sps_pkg::PAT_OFF;
            evt_start_en_r <= 1'b0;
            evt_clear_en_r <= 1'b0;
            aux1_fn_r      <= sps_pkg::FN_NONE;
            alarm1_fn_r    <= sps_pkg::FN_ALARM;
        end else begin
            if (wr_acc && paddr == sps_pkg::OFS_EVT_ASGN) begin
                evt_start_en_r <= pwdata[sps_pkg::BIT_EVT_START];
                evt_clear_en_r <= pwdata[sps_pkg::BIT_EVT_CLEAR];
            end
            if (wr_acc && paddr == sps_pkg::OFS_OUT_ASGN) begin
                aux1_fn_r   <= sps_pkg::sps_outfn_t'(pwdata[2:0]);
                alarm1_fn_r <= sps_pkg::sps_outfn_t'(pwdata[sps_pkg::POS_FIRST_ALARM_FUNCTION_FN +: 3]);
            end
            if (wr_pattern) begin
                pattern_r <= sps_pkg::sps_pattern_t'(wpat);
                if (wpat == 2'(sps_pkg::PAT_OFF)) begin
                    evt_start_en_r <= 1'b0;
                    if (pat_on) begin
                        alarm1_fn_r <= heater_alarm_fitted ? sps_pkg::FN_HEATER
                                                           : sps_pkg::FN_ALARM;
                    end
                end else if (!pat_on) begin
                    aux1_fn_r <= cooling_out_used ? sps_pkg::FN_COOL
                                                  : sps_pkg::FN_END;
                end
            end
        end
    end

    // soak duration, unit and wait band; out-of-range writes are ignored
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            soak_dur_r <= sps_pkg::SOAK_RST;
            unit_r     <= sps_pkg::UNIT_MIN;
            band_r     <= sps_pkg::BAND_OFF;
            band_ana_r <= 1'b0;
        end else if (wr_acc) begin
            if (paddr == sps_pkg::OFS_SOAK_DUR && pwdata[13:0] >= sps_pkg::SOAK_MIN
                && pwdata[13:0] <= sps_pkg::SOAK_MAX && pwdata[31:14] == 18'h00000) begin
                soak_dur_r <= pwdata[13:0];
            end
            if (paddr == sps_pkg::OFS_SOAK_UNIT && pwdata[1:0] <= 2'(sps_pkg::UNIT_HOUR)) begin
                unit_r <= sps_pkg::sps_unit_t'(pwdata[1:0]);
            end
            // tenths of a degree or hundredths of %FS share one code range
            if (paddr == sps_pkg::OFS_WAIT_BAND && pwdata[15:0] <= sps_pkg::BAND_MAX) begin
                band_r     <= pwdata[15:0];
                band_ana_r <= pwdata[sps_pkg::BIT_BAND_ANA];
            end
        end
    end

    // end display blink: half-second phases while the end flag stands
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            blink_cnt_r <= '0;
            blink_r     <= 1'b0;
        end else if (!end_r) begin
            blink_cnt_r <= '0;
            blink_r     <= 1'b0;
        end else if (blink_cnt_r == BLK_LAST) begin
            blink_cnt_r <= '0;
            blink_r     <= !blink_r;
        end else begin
            blink_cnt_r <= blink_cnt_r + BLKW'(1);
        end
    end

    // memory write request per start or reset; the count lets software watch wear
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            nvm_r     <= 1'b0;
            nvm_cnt_r <= 16'h0000;
        end else begin
            nvm_r <= go_evt || rst_evt;
            if (go_evt || rst_evt) begin
                nvm_cnt_r <= nvm_cnt_r + 16'h0001;
            end
        end
    end

    // read data is latched in the setup cycle and shown in the access cycle
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (rd_setup) begin
            pslverr_r <= !addr_ok;
            unique case (paddr)
                sps_pkg::OFS_PATTERN:   prdata_r <= {30'h0, pattern_r};
                sps_pkg::OFS_START:     prdata_r <= {31'h0, start_lvl};
                sps_pkg::OFS_SOAK_DUR:  prdata_r <= {18'h0, soak_dur_r};
                sps_pkg::OFS_SOAK_UNIT: prdata_r <= {30'h0, unit_r};
                sps_pkg::OFS_WAIT_BAND: prdata_r <= {15'h0, band_ana_r, band_r};
                sps_pkg::OFS_EVT_ASGN:  prdata_r <= {30'h0, evt_clear_en_r, evt_start_en_r};
                sps_pkg::OFS_RUNSTOP:   prdata_r <= {31'h0, run_r};
                sps_pkg::OFS_STATUS:    prdata_r <= {27'h0, blink_r, in_band, run_r,
                                                     active_r, end_r};
                sps_pkg::OFS_ELAPSED:   prdata_r <= {18'h0, elapsed_r};
                sps_pkg::OFS_REMAIN:    prdata_r <= {18'h0, (elapsed_r >= soak_dur_r)
                                                     ? 14'h0000 : soak_dur_r - elapsed_r};
                sps_pkg::OFS_OUT_ASGN:  prdata_r <= {21'h0, alarm1_fn_r, 5'h00, aux1_fn_r};
                sps_pkg::OFS_NVM_CNT:   prdata_r <= {16'h0, nvm_cnt_r};
                default:                prdata_r <= 32'h0000_0000;
            endcase
        end
    end

    // output routing by assigned function
    function automatic logic route_fn(input sps_pkg::sps_outfn_t fn, input logic endv,
                                      input logic alm, input logic ha, input logic cool);
        logic v;
        v = 1'b0;
        unique case (fn)
            sps_pkg::FN_END:    v = endv;
            sps_pkg::FN_ALARM:  v = alm;
            sps_pkg::FN_HEATER: v = ha;
            sps_pkg::FN_COOL:   v = cool;
            default:            v = 1'b0;
        endcase
        return v;
    endfunction : route_fn

    assign pready          = 1'b1;
    assign pslverr         = pslverr_r && psel && penable;
    assign prdata          = prdata_r;
    assign run_mode        = run_r;
    assign prog_end        = end_r;
    assign aux1_out        = route_fn(aux1_fn_r, end_r, alarm1_src, heater_alarm_src,
                                      cooling_src);
    assign alarm1_out      = route_fn(alarm1_fn_r, end_r, alarm1_src, heater_alarm_src,
                                      cooling_src);
    assign disp_show_end   = blink_r;
    assign comm_end_status = end_r;
    assign nvm_write       = nvm_r;
endmodule : sps_sequencer
`default_nettype wire
